/* verilog/ca_map.svh */
// Register map, field positions and counts for the counter array control block
//
// Notes on behaviour
// R1 - Counter runs only while run bit set
// R2 - Overflow request needs flag and enable both
// R3 - Width select bit picks 10-bit or 16-bit
// R4 - Clock select: prescaler, timer0 overflow, external pin
// R5 - Overflow flag set on rollover, software-cleared only
// R6 - Channel events set their status flags
// R7 - All eight requests ORed into one
// R8 - Software clears serviced flag after reading flags
// R9 - Reserved bits read zero; select 11 idle
`ifndef CA_MAP_SVH
`define CA_MAP_SVH

// ==========================================================================
// Register addresses and reset values
`define CA_FLAGS_ADDR      8'ha5
`define CA_CTRL1_ADDR      8'hbc
`define CA_FLAGS_RESET     8'h00
`define CA_CTRL1_RESET     8'h00
`define CA_CTRL1_WMASK     8'h77

// ==========================================================================
// Counter limits and external pin spacing
`define CA_COUNT_ZERO      16'h0000
`define CA_COUNT_MAX16     16'hffff
`define CA_COUNT_MAX10     10'h3ff
`define CA_EXT_MIN_PERIOD  3'h4
`define CA_EXT_ONE         3'h1

`endif

/* verilog/ca_pkg.sv */
// Types shared by the counter array control block
package ca_pkg;

    // ======================================================================
    // Clock source select codes
    typedef enum logic [1:0] {
        CA_SRC_PRESCALER = 2'b00,
        CA_SRC_TIMER0    = 2'b01,
        CA_SRC_EXT_PIN   = 2'b10,
        CA_SRC_NONE      = 2'b11
    } ca_clk_sel_t;

    // ======================================================================
    // Unit 1 control register layout
    typedef struct packed {
        logic        reserved7;
        logic        counter_run;
        logic        overflow_irq_enable;
        logic        idle_behaviour_select;
        logic        reserved3;
        logic        ten_bit_width_select;
        ca_clk_sel_t clk_sel;
    } ca_ctrl_t;

    // ======================================================================
    // Shared status register layout
    typedef struct packed {
        logic unit1_overflow_flag;
        logic channel5_event_flag;
        logic channel4_event_flag;
        logic channel3_event_flag;
        logic unit0_overflow_flag;
        logic channel2_event_flag;
        logic channel1_event_flag;
        logic channel0_event_flag;
    } ca_status_t;

endpackage : ca_pkg

/* verilog/ca_clk_select.sv */
// Counter clock source selection with rate-limited external pin
`timescale 1ns/1ps
`include "ca_map.svh"

module ca_clk_select (
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                resetn,
    // Source choice
    input  wire ca_pkg::ca_clk_sel_t clk_sel,
    // Candidate sources
    input  wire logic                prescaler_tick,
    input  wire logic                timer0_overflow,
    input  wire logic                ext_clock_pin,
    // Selected count pulse
    output logic                     tick
);
    import ca_pkg::*;

    logic       ext_prev;
    logic [2:0] ext_gap;
    logic       ext_edge;

    // Rising edge counts only once the minimum spacing has passed since the last counted edge
    assign ext_edge = ext_clock_pin && !ext_prev && (ext_gap == 3'h0);

    // Previous pin level for edge detection
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ext_prev <= 1'b0;
        end else begin
            ext_prev <= ext_clock_pin;
        end
    end

    // Spacing counter; faster pin toggling is dropped, not queued
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ext_gap <= 3'h0;
        end else if (ext_edge) begin
            ext_gap <= `CA_EXT_MIN_PERIOD - `CA_EXT_ONE; // R4
        end else if (ext_gap != 3'h0) begin
            ext_gap <= ext_gap - `CA_EXT_ONE;
        end
    end

    // Source multiplexer; code 11 gives no pulses at all
    always_comb begin
        case (clk_sel)
            CA_SRC_PRESCALER: tick = prescaler_tick;  // R4
            CA_SRC_TIMER0:    tick = timer0_overflow; // R4
            CA_SRC_EXT_PIN:   tick = ext_edge;        // R4
            CA_SRC_NONE:      tick = 1'b0;            // R9
            default:          tick = 1'b0;
        endcase
    end

endmodule : ca_clk_select

/* verilog/ca_unit_ctrl.sv */
// Counter array unit 1 control, shared status flags and combined interrupt
`timescale 1ns/1ps
`include "ca_map.svh"

module ca_unit_ctrl (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              resetn,
    // Special function register port
    input  wire logic [7:0]        sfr_addr,
    input  wire logic              sfr_wr,
    input  wire logic [7:0]        sfr_wdata,
    input  wire logic              sfr_rd,
    output logic [7:0]             sfr_rdata,
    // Count sources for unit 1
    input  wire logic              prescaler_tick,
    input  wire logic              timer0_overflow,
    input  wire logic              ext_clock_pin,
    // Unit 0 and channel events
    input  wire logic              unit0_rollover,
    input  wire logic              unit0_overflow_irq_enable,
    input  wire logic [5:0]        channel_event,
    input  wire logic [5:0]        channel_irq_enable,
    // Unit 1 state and configuration
    output logic [15:0]            unit1_count,
    output ca_pkg::ca_ctrl_t       unit1_ctrl,
    output ca_pkg::ca_status_t     flags,
    // Processor interrupt request
    output logic                   counter_array_irq
);
    import ca_pkg::*;

    logic        tick;
    logic        wr_ctrl;
    logic        wr_flags;
    logic [16:0] next_count;
    logic        rollover;
    ca_status_t  hw_set;
    ca_status_t  next_flags;
    logic        next_irq;

    // ======================================================================
    // Next count with wrap at the selected width; bit 16 marks rollover
    function automatic logic [16:0] ca_next_count(input logic [15:0] cnt, input logic ten_bit);
        logic [16:0] res;
        res = {1'b0, cnt};
        if (ten_bit) begin
            if (cnt[9:0] == `CA_COUNT_MAX10) begin
                res = {1'b1, `CA_COUNT_ZERO};
            end else begin
                res = {7'h00, cnt[9:0] + 10'h001};
            end
        end else begin
            if (cnt == `CA_COUNT_MAX16) begin
                res = {1'b1, `CA_COUNT_ZERO};
            end else begin
                res = {1'b0, cnt + 16'h0001};
            end
        end
        return res;
    endfunction : ca_next_count

    // ======================================================================
    // Source selection
    ca_clk_select u_clk_select (
        .clock           (clock),
        .resetn          (resetn),
        .clk_sel         (unit1_ctrl.clk_sel),
        .prescaler_tick  (prescaler_tick),
        .timer0_overflow (timer0_overflow),
        .ext_clock_pin   (ext_clock_pin),
        .tick            (tick)
    );

    // ======================================================================
    // Register decode
    assign wr_ctrl  = sfr_wr && (sfr_addr == `CA_CTRL1_ADDR);
    assign wr_flags = sfr_wr && (sfr_addr == `CA_FLAGS_ADDR);

    // Control register; reserved bits are masked so they stay zero
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            unit1_ctrl <= ca_ctrl_t'(`CA_CTRL1_RESET);
        end else if (wr_ctrl) begin
            unit1_ctrl <= ca_ctrl_t'(sfr_wdata & `CA_CTRL1_WMASK); // R1 R9
        end
    end

    // ======================================================================
    // Unit 1 counter
    assign next_count = ca_next_count(unit1_count, unit1_ctrl.ten_bit_width_select); // R3
    assign rollover   = unit1_ctrl.counter_run && tick && next_count[16];

    // Counter advances only on a selected pulse while running
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            unit1_count <= `CA_COUNT_ZERO;
        end else if (unit1_ctrl.counter_run && tick) begin
            unit1_count <= next_count[15:0]; // R1 R3
        end
    end

    // ======================================================================
    // Status flags: write stores, hardware sets; a set in the write cycle wins
    always_comb begin
        hw_set                     = ca_status_t'(`CA_FLAGS_RESET);
        hw_set.unit1_overflow_flag = rollover;          // R5
        hw_set.unit0_overflow_flag = unit0_rollover;    // R5
        hw_set.channel0_event_flag = channel_event[0];  // R6
        hw_set.channel1_event_flag = channel_event[1];
        hw_set.channel2_event_flag = channel_event[2];
        hw_set.channel3_event_flag = channel_event[3];
        hw_set.channel4_event_flag = channel_event[4];
        hw_set.channel5_event_flag = channel_event[5];
        next_flags = (wr_flags ? ca_status_t'(sfr_wdata) : flags) | hw_set; // R5
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            flags <= ca_status_t'(`CA_FLAGS_RESET);
        end else begin
            flags <= next_flags; // R5 R6
        end
    end

    // ======================================================================
    // Combined request, registered so the pin is glitch free (one cycle behind flags)
    always_comb begin
        next_irq = (flags.unit1_overflow_flag && unit1_ctrl.overflow_irq_enable)   // R2
                || (flags.unit0_overflow_flag && unit0_overflow_irq_enable)         // R2
                || (flags.channel0_event_flag && channel_irq_enable[0])
                || (flags.channel1_event_flag && channel_irq_enable[1])
                || (flags.channel2_event_flag && channel_irq_enable[2])
                || (flags.channel3_event_flag && channel_irq_enable[3])
                || (flags.channel4_event_flag && channel_irq_enable[4])
                || (flags.channel5_event_flag && channel_irq_enable[5]);          // R7
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            counter_array_irq <= 1'b0;
        end else begin
            counter_array_irq <= next_irq; // R7
        end
    end

    // ======================================================================
    // Read data, one cycle after the strobe; unmapped addresses read zero
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            case (sfr_addr)
                `CA_CTRL1_ADDR: sfr_rdata <= unit1_ctrl & `CA_CTRL1_WMASK; // R9
                `CA_FLAGS_ADDR: sfr_rdata <= flags;
                default:        sfr_rdata <= 8'h00;
            endcase
        end else begin
            sfr_rdata <= 8'h00;
        end
    end

    // ======================================================================
    // Checks
    property p_stop_holds;
        @(posedge clock) disable iff (!resetn)
        !unit1_ctrl.counter_run |=> (unit1_count == $past(unit1_count));
    endproperty
    a_stop_holds: assert property (p_stop_holds) else $error("counter moved while stopped"); // R1

    property p_run_by_write;
        @(posedge clock) disable iff (!resetn)
        $changed(unit1_ctrl.counter_run) |-> $past(wr_ctrl);
    endproperty
    a_run_by_write: assert property (p_run_by_write) else $error("run bit changed without write"); // R1

    property p_run_counts;
        @(posedge clock) disable iff (!resetn)
        (unit1_ctrl.counter_run && tick && !next_count[16]
            && (!unit1_ctrl.ten_bit_width_select || unit1_count[15:10] == 6'h00))
            |=> (unit1_count == $past(unit1_count) + 16'h0001);
    endproperty
    a_run_counts: assert property (p_run_counts) else $error("counter did not advance"); // R1

    property p_ovf_irq;
        @(posedge clock) disable iff (!resetn)
        (flags.unit1_overflow_flag && unit1_ctrl.overflow_irq_enable) |=> counter_array_irq;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow request missing"); // R2

    property p_no_source_no_irq;
        @(posedge clock) disable iff (!resetn)
        (flags == ca_status_t'(`CA_FLAGS_RESET)) |=> !counter_array_irq;
    endproperty
    a_no_source_no_irq: assert property (p_no_source_no_irq) else $error("request without flag"); // R7

    property p_ten_bit_range;
        @(posedge clock) disable iff (!resetn)
        (unit1_ctrl.ten_bit_width_select && unit1_ctrl.counter_run && tick) |=> (unit1_count[15:10] == 6'h00);
    endproperty
    a_ten_bit_range: assert property (p_ten_bit_range) else $error("10-bit count out of range"); // R3

    property p_rollover_sets;
        @(posedge clock) disable iff (!resetn)
        rollover |=> flags.unit1_overflow_flag && (unit1_count == `CA_COUNT_ZERO);
    endproperty
    a_rollover_sets: assert property (p_rollover_sets) else $error("rollover flag not set"); // R5

    property p_sw_clear_only;
        @(posedge clock) disable iff (!resetn)
        $fell(flags.unit1_overflow_flag) |-> $past(wr_flags) && !$past(sfr_wdata[7]);
    endproperty
    a_sw_clear_only: assert property (p_sw_clear_only) else $error("overflow flag cleared by hardware"); // R5

    property p_chan_sets;
        @(posedge clock) disable iff (!resetn)
        channel_event[3] |=> flags.channel3_event_flag;
    endproperty
    a_chan_sets: assert property (p_chan_sets) else $error("channel 3 flag not set"); // R6

    property p_sel_none;
        @(posedge clock) disable iff (!resetn)
        (unit1_ctrl.clk_sel == CA_SRC_NONE) |-> !tick;
    endproperty
    a_sel_none: assert property (p_sel_none) else $error("pulse with undefined source"); // R9

    property p_reserved_zero;
        @(posedge clock) disable iff (!resetn)
        (sfr_rd && sfr_addr == `CA_CTRL1_ADDR) |=> (sfr_rdata[7] == 1'b0) && (sfr_rdata[3] == 1'b0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read as one"); // R9

    // Main scenarios
    c_rollover:  cover property (@(posedge clock) disable iff (!resetn) rollover);
    c_ten_wrap:  cover property (@(posedge clock) disable iff (!resetn)
                                 rollover && unit1_ctrl.ten_bit_width_select);
    c_irq_rise:  cover property (@(posedge clock) disable iff (!resetn) $rose(counter_array_irq));
    c_ext_count: cover property (@(posedge clock) disable iff (!resetn)
                                 tick && unit1_ctrl.clk_sel == CA_SRC_EXT_PIN && unit1_ctrl.counter_run);

endmodule : ca_unit_ctrl

/* dv/tb.sv */
// Self-checking testbench for the counter array unit control block
`timescale 1ns/1ps
`include "ca_map.svh"

module tb;
    import ca_pkg::*;

    // ======================================================================
    // Stimulus, observed outputs and bookkeeping
    logic               clock;
    logic               resetn;
    logic [7:0]         sfr_addr;
    logic               sfr_wr;
    logic [7:0]         sfr_wdata;
    logic               sfr_rd;
    logic [7:0]         sfr_rdata;
    logic               prescaler_tick;
    logic               timer0_overflow;
    logic               ext_clock_pin;
    logic               unit0_rollover;
    logic               unit0_overflow_irq_enable;
    logic [5:0]         channel_event;
    logic [5:0]         channel_irq_enable;
    logic [15:0]        unit1_count;
    ca_ctrl_t           unit1_ctrl;
    ca_status_t         flags;
    logic               counter_array_irq;
    int                 error_cnt;
    int                 total_checks;
    int                 n;
    logic [15:0]        exp_cnt;
    logic [7:0]         v;
    logic [7:0]         rv;
    logic [7:0]         got;

    ca_unit_ctrl dut (.clock(clock), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .prescaler_tick(prescaler_tick),
        .timer0_overflow(timer0_overflow), .ext_clock_pin(ext_clock_pin), .unit0_rollover(unit0_rollover),
        .unit0_overflow_irq_enable(unit0_overflow_irq_enable), .channel_event(channel_event),
        .channel_irq_enable(channel_irq_enable), .unit1_count(unit1_count), .unit1_ctrl(unit1_ctrl),
        .flags(flags), .counter_array_irq(counter_array_irq));

    // 40 MHz clock, 25 ns period
    initial clock = 1'b0;
    always #12.5 clock = ~clock;

    // ======================================================================
    // Helpers
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    // Strobes last one cycle, launched off the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clock);
        sfr_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clock);
        sfr_rd = 1'b0;
        d = sfr_rdata;
    endtask : rd

    // Pulses spaced 8 cycles so the external pin limit never drops one
    task automatic pulse(input logic [2:0] m, input int cnt);
        repeat (cnt) begin
            @(negedge clock);
            {ext_clock_pin, timer0_overflow, prescaler_tick} = m;
            @(negedge clock);
            {ext_clock_pin, timer0_overflow, prescaler_tick} = 3'h0;
            repeat (6) @(negedge clock);
        end
    endtask : pulse

    function automatic int bitpos(input int ch);
        return (ch < 3) ? ch : ch + 1;
    endfunction : bitpos

    function automatic logic exp_irq(input logic [7:0] f, input logic ov1_en, input logic u0_en,
                                     input logic [5:0] ce);
        logic [7:0] en;
        en = {ov1_en, ce[5:3], u0_en, ce[2:0]};
        return |(f & en);
    endfunction : exp_irq

    // Hang guard: the tests need about 9000 cycles
    initial begin
        #750000;
        error_cnt++;
        final_report();
    end

    // ======================================================================
    // Main sequence
    initial begin
        resetn = 1'b0;
        {sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = '0;
        {ext_clock_pin, timer0_overflow, prescaler_tick, unit0_rollover} = 4'h0;
        unit0_overflow_irq_enable = 1'b0;
        channel_event = 6'h00;
        channel_irq_enable = 6'h00;
        error_cnt = 0;
        total_checks = 0;
        exp_cnt = 16'h0000;
        void'($urandom(87));
        repeat (10) @(negedge clock);
        resetn = 1'b1;
        // Reset values and reserved bits
        rd(`CA_CTRL1_ADDR, got);
        chk("ctrl reset", 16'h0000, {8'h00, got});
        rd(`CA_FLAGS_ADDR, got);
        chk("flags reset", 16'h0000, {8'h00, got});
        wr(`CA_CTRL1_ADDR, 8'hff);
        rd(`CA_CTRL1_ADDR, got);
        chk("ctrl reserved", 16'h0077, {8'h00, got});
        // Read data stands one cycle only, then returns to zero
        @(negedge clock);
        chk("rdata idle", 16'h0000, {8'h00, sfr_rdata});
        wr(8'h10, 8'hff);
        rd(8'h10, got);
        chk("unmapped", 16'h0000, {8'h00, got});
        // Each source counts only when selected; code 11 never counts
        for (int s = 0; s < 4; s++) begin
            wr(`CA_CTRL1_ADDR, {6'b010000, s[1:0]});
            pulse(3'h7 & ~(3'h1 << s), 3);
            n = $urandom_range(12, 3);
            pulse((s < 3) ? (3'h1 << s) : 3'h0, n);
            if (s < 3) exp_cnt = exp_cnt + n[15:0];
            chk("count", exp_cnt, unit1_count);
        end
        wr(`CA_CTRL1_ADDR, 8'h00);
        pulse(3'h7, 4);
        chk("count stopped", exp_cnt, unit1_count);
        // Pin edges two cycles apart: only every second one counts
        wr(`CA_CTRL1_ADDR, 8'h42);
        repeat (8) begin
            @(negedge clock);
            ext_clock_pin = 1'b1;
            @(negedge clock);
            ext_clock_pin = 1'b0;
        end
        repeat (6) @(negedge clock);
        exp_cnt = exp_cnt + 16'h4;
        chk("pin rate", exp_cnt, unit1_count);
        // Ten-bit wrap sets the unit 1 flag, which hardware never clears
        wr(`CA_CTRL1_ADDR, 8'h44);
        pulse(3'h1, 1023 - int'(exp_cnt));
        chk("count top", 16'h03ff, unit1_count);
        chk("flags", 16'h0000, {8'h00, flags});
        pulse(3'h1, 1);
        chk("count wrap", 16'h0000, unit1_count);
        chk("flags", 16'h0080, {8'h00, flags});
        chk("irq", 16'h0000, {15'h0, counter_array_irq});
        pulse(3'h1, 2);
        chk("flags", 16'h0080, {8'h00, flags});
        wr(`CA_CTRL1_ADDR, 8'h24);
        repeat (2) @(negedge clock);
        chk("irq", 16'h0001, {15'h0, counter_array_irq});
        wr(`CA_FLAGS_ADDR, 8'h00);
        repeat (2) @(negedge clock);
        chk("flags", 16'h0000, {8'h00, flags});
        chk("irq", 16'h0000, {15'h0, counter_array_irq});
        wr(`CA_CTRL1_ADDR, 8'h00);
        // Channel events and unit 0 rollover each raise their own flag
        for (int ch = 0; ch < 7; ch++) begin
            channel_irq_enable = (ch < 6) ? (6'h01 << ch) : 6'h00;
            unit0_overflow_irq_enable = (ch == 6);
            @(negedge clock);
            channel_event = (ch < 6) ? (6'h01 << ch) : 6'h00;
            unit0_rollover = (ch == 6);
            @(negedge clock);
            channel_event = 6'h00;
            unit0_rollover = 1'b0;
            @(negedge clock);
            chk("flags", (ch < 6) ? (16'h1 << bitpos(ch)) : 16'h0008, {8'h00, flags});
            chk("irq", 16'h0001, {15'h0, counter_array_irq});
            // Service as software would: read the flags, then clear only the serviced one
            v = (ch < 6) ? 8'(8'h01 << bitpos(ch)) : 8'h08;
            rd(`CA_FLAGS_ADDR, got);
            chk("flags read", {8'h00, v}, {8'h00, got});
            wr(`CA_FLAGS_ADDR, got & ~v);
        end
        // Random flag contents against random enables
        repeat (8) begin
            v = 8'($urandom);
            rv = 8'($urandom) & 8'hbf;
            channel_irq_enable = 6'($urandom);
            unit0_overflow_irq_enable = 1'($urandom);
            wr(`CA_CTRL1_ADDR, rv);
            wr(`CA_FLAGS_ADDR, v);
            rd(`CA_FLAGS_ADDR, got);
            chk("flags rw", {8'h00, v}, {8'h00, got});
            chk("irq", {15'h0, exp_irq(v, rv[5], unit0_overflow_irq_enable, channel_irq_enable)},
                {15'h0, counter_array_irq});
            rd(`CA_CTRL1_ADDR, got);
            chk("ctrl rw", {8'h00, rv & 8'h37}, {8'h00, got});
            chk("ctrl out", {8'h00, rv & `CA_CTRL1_WMASK}, {8'h00, unit1_ctrl});
        end
        // Clearing write in the same cycle as an event: the event wins
        @(negedge clock);
        sfr_addr = `CA_FLAGS_ADDR;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b1;
        channel_event = 6'h02;
        @(negedge clock);
        sfr_wr = 1'b0;
        channel_event = 6'h00;
        chk("flags race", 16'h0002, {8'h00, flags});
        final_report();
    end

endmodule : tb
